// >>> logic/ulpc_map.svh
// constants for the user logic port control block
`ifndef ULPC_MAP_SVH
`define ULPC_MAP_SVH
`define ULPC_DIR_IN          1'b0
`define ULPC_DIR_OUT         1'b1
`define ULPC_FN_WIDTH        2
`define ULPC_FN_USER         2'h1
`define ULPC_V1_GP1_IN       1
`define ULPC_V1_GP1_OUT      1
`define ULPC_V1_GP1_DIR      1
`define ULPC_V1_GP2_IN       8
`define ULPC_V1_GP2_OUT      8
`define ULPC_V1_GP2_DIR      8
`define ULPC_V1_GP3_IN       5
`define ULPC_V1_GP3_OUT      5
`define ULPC_V1_GP3_DIR      5
`define ULPC_V2_GP1_IN       12
`define ULPC_V2_GP1_OUT      12
`define ULPC_V2_GP1_DIR      6
`define ULPC_V2_GP2_IN       4
`define ULPC_V2_GP2_OUT      3
`define ULPC_V2_GP2_DIR      4
`define ULPC_V2_GP2_OUT_BASE 4
`define ULPC_GP_MAXPINS      13
`endif

// >>> logic/ulpc_pkg.sv
// types for the user logic port control block
package ulpc_pkg;
    typedef enum logic {
        ULPC_VARIANT_ONE,
        ULPC_VARIANT_TWO
    } ulpc_variant_t;
    typedef logic [1:0] ulpc_fn_t;
endpackage

// >>> logic/ulpc_pin_if.sv
// per-pin user request and pad drive bundle between the port modules
`timescale 1ns/1ps
interface ulpc_pin_if;
    logic user_out;
    logic user_dir;
    logic user_sel;
    logic pad_out;
    logic pad_oe;
    logic term_low;
    modport ctrl (input user_out, user_dir, user_sel,
                  output pad_out, pad_oe, term_low);
    modport top (output user_out, user_dir, user_sel,
                 input pad_out, pad_oe, term_low);
endinterface

// >>> logic/ulpc_pin.sv
// one controllable pin: input synchroniser and registered drive gate
`timescale 1ns/1ps
`include "ulpc_map.svh"
module ulpc_pin (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic pad_in,
    output logic      user_in,
    ulpc_pin_if.ctrl  pin
);
    logic [2:0] sync;
    // three stages; the first is read only by the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], pad_in};
        end
    end
    // a change counts once the second and third stages agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            user_in <= 1'b0;
        end else if (sync[1] == sync[2]) begin
            user_in <= sync[2];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin.pad_out  <= 1'b0;
            pin.pad_oe   <= 1'b0;
            pin.term_low <= 1'b0;
        end else begin
            pin.pad_oe   <= pin.user_sel & (pin.user_dir == `ULPC_DIR_OUT);
            pin.pad_out  <= pin.user_sel & (pin.user_dir == `ULPC_DIR_OUT)
                            & pin.user_out;
            pin.term_low <= pin.user_sel & (pin.user_dir == `ULPC_DIR_OUT)
                            & ~pin.user_out;
        end
    end
endmodule // ulpc_pin

// >>> logic/ulpc_port_ctrl.sv
// port control for the user logic area: trig, sync and gp ports
`timescale 1ns/1ps
`include "ulpc_map.svh"
// Behaviour
// - A direction bit of 0 makes a pin an input and 1 makes it an output.
// - The synchronised pin level is always given to user logic; the variant two gp2 fixed output pins 4..6 are not read back.
// - User output and direction act only while the pin function is user.
// - Every pin input is synchronised to the data clock first.
// - Direction 1 with output 0 selects low-impedance input termination; only the trig and sync pins bring it out, as trig_term_low and sync_term_low.
// - User logic has no control over output impedance.
// - The output value reaches a pin only while its direction is output.
// - Variant one has one-pin trig, sync and first gp ports.
// - Variant one second gp port has 8 differential pins.
// - Variant one third gp port has 5 single-ended pins.
// - Variant two first gp port has 12 pins and 6 shared direction bits.
// - Variant two second gp port has 4 fixed inputs and 3 fixed outputs.
// - Variant two has a fixed star input and a fixed star output.
module ulpc_port_ctrl
    import ulpc_pkg::*;
#(
    parameter ulpc_pkg::ulpc_variant_t VARIANT = ulpc_pkg::ULPC_VARIANT_ONE
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire ulpc_pkg::ulpc_fn_t   trig_fn,
    input  wire ulpc_pkg::ulpc_fn_t   sync_fn,
    input  wire ulpc_pkg::ulpc_fn_t   gp1_fn,
    input  wire ulpc_pkg::ulpc_fn_t   gp2_fn,
    input  wire ulpc_pkg::ulpc_fn_t   gp3_fn,
    input  wire logic                 trig_pad_in,
    input  wire logic                 sync_pad_in,
    input  wire logic [11:0]          gp1_pad_in,
    input  wire logic [7:0]           gp2_pad_in,
    input  wire logic [4:0]           gp3_pad_in,
    input  wire logic                 star_in_pad,
    output logic                      trig_pad_out,
    output logic                      trig_pad_oe,
    output logic                      trig_term_low,
    output logic                      sync_pad_out,
    output logic                      sync_pad_oe,
    output logic                      sync_term_low,
    output logic [11:0]               gp1_pad_out,
    output logic [11:0]               gp1_pad_oe,
    output logic [7:0]                gp2_pad_out,
    output logic [7:0]                gp2_pad_oe,
    output logic [4:0]                gp3_pad_out,
    output logic [4:0]                gp3_pad_oe,
    output logic                      star_out_pad,
    output logic                      trig_in,
    input  wire logic                 trig_out,
    input  wire logic                 trig_dir,
    output logic                      sync_in,
    input  wire logic                 sync_out,
    input  wire logic                 sync_dir,
    output logic [11:0]               gp1_in,
    input  wire logic [11:0]          gp1_out,
    input  wire logic [11:0]          gp1_dir,
    output logic [7:0]                gp2_in,
    input  wire logic [7:0]           gp2_out,
    input  wire logic [7:0]           gp2_dir,
    output logic [4:0]                gp3_in,
    input  wire logic [4:0]           gp3_out,
    input  wire logic [4:0]           gp3_dir,
    output logic                      star_in,
    input  wire logic                 star_out
);
    import ulpc_pkg::*;

    // widths per variant, fixed at elaboration
    localparam bit V2 = (VARIANT == ULPC_VARIANT_TWO);
    localparam int GP1_IN  = V2 ? `ULPC_V2_GP1_IN  : `ULPC_V1_GP1_IN;
    localparam int GP1_DIR = V2 ? `ULPC_V2_GP1_DIR : `ULPC_V1_GP1_DIR;
    localparam int GP2_IN  = V2 ? `ULPC_V2_GP2_IN  : `ULPC_V1_GP2_IN;
    localparam int GP2_OUT = V2 ? `ULPC_V2_GP2_OUT : `ULPC_V1_GP2_OUT;
    localparam int GP2_PIN = V2 ? (`ULPC_V2_GP2_OUT_BASE + GP2_OUT)
                                : `ULPC_V1_GP2_IN;
    localparam int GP3_PIN = V2 ? 0 : `ULPC_V1_GP3_IN;

    // trig and sync pins
    ulpc_pin_if trig_if ();
    ulpc_pin_if sync_if ();
    assign trig_if.user_out = trig_out;
    assign trig_if.user_dir = trig_dir;
    assign trig_if.user_sel = (trig_fn == `ULPC_FN_USER);
    assign sync_if.user_out = sync_out;
    assign sync_if.user_dir = sync_dir;
    assign sync_if.user_sel = (sync_fn == `ULPC_FN_USER);

    ulpc_pin u_trig (
        .mclk    (mclk),
        .reset   (reset),
        .pad_in  (trig_pad_in),
        .user_in (trig_in),
        .pin     (trig_if.ctrl)
    );
    ulpc_pin u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .pad_in  (sync_pad_in),
        .user_in (sync_in),
        .pin     (sync_if.ctrl)
    );
    assign trig_pad_out  = trig_if.pad_out;
    assign trig_pad_oe   = trig_if.pad_oe;
    assign trig_term_low = trig_if.term_low;
    assign sync_pad_out  = sync_if.pad_out;
    assign sync_pad_oe   = sync_if.pad_oe;
    assign sync_term_low = sync_if.term_low;
    // no output impedance control is offered anywhere

    // first gp port; variant two shares one direction bit per pin pair
    genvar i;
    generate
        for (i = 0; i < `ULPC_V2_GP1_IN; i++) begin : g_gp1
            if (i < GP1_IN) begin : g_on
                ulpc_pin_if pif ();
                assign pif.user_out = gp1_out[i];
                // one direction bit per pin, or per pin pair in variant two
                assign pif.user_dir =
                    gp1_dir[i / (GP1_IN / GP1_DIR)];
                assign pif.user_sel = (gp1_fn == `ULPC_FN_USER);
                ulpc_pin u_pin (
                    .mclk    (mclk),
                    .reset   (reset),
                    .pad_in  (gp1_pad_in[i]),
                    .user_in (gp1_in[i]),
                    .pin     (pif.ctrl)
                );
                assign gp1_pad_out[i] = pif.pad_out;
                assign gp1_pad_oe[i]  = pif.pad_oe;
            end else begin : g_off
                // absent pins idle: not driven, read as zero
                always_ff @(posedge mclk) begin
                    gp1_in[i]      <= 1'b0;
                    gp1_pad_out[i] <= 1'b0;
                    gp1_pad_oe[i]  <= 1'b0;
                end
            end
        end

        // second gp port: free pins in variant one, fixed split in two
        for (i = 0; i < `ULPC_V1_GP2_IN; i++) begin : g_gp2
            if (i < GP2_PIN) begin : g_on
                ulpc_pin_if pif ();
                logic       pin_in;
                if (!V2) begin : g_free
                    assign pif.user_out = gp2_out[i];
                    assign pif.user_dir = gp2_dir[i];
                end else if (i < GP2_IN) begin : g_fin
                    // fixed input; user direction ignored
                    assign pif.user_out = 1'b0;
                    assign pif.user_dir = `ULPC_DIR_IN;
                end else begin : g_fout
                    // fixed output pins 4..6 take out bits 0..2
                    assign pif.user_out = gp2_out[i - `ULPC_V2_GP2_OUT_BASE];
                    assign pif.user_dir = `ULPC_DIR_OUT;
                end
                assign pif.user_sel = (gp2_fn == `ULPC_FN_USER);
                ulpc_pin u_pin (
                    .mclk    (mclk),
                    .reset   (reset),
                    .pad_in  (gp2_pad_in[i]),
                    .user_in (pin_in),
                    .pin     (pif.ctrl)
                );
                assign gp2_pad_out[i] = pif.pad_out;
                assign gp2_pad_oe[i]  = pif.pad_oe;
            end else begin : g_off
                always_ff @(posedge mclk) begin
                    gp2_pad_out[i] <= 1'b0;
                    gp2_pad_oe[i]  <= 1'b0;
                end
            end
        end

        // user input bits of the second gp port
        for (i = 0; i < `ULPC_V1_GP2_IN; i++) begin : g_gp2_in
            if (i < GP2_IN) begin : g_on
                assign gp2_in[i] = g_gp2[i].g_on.pin_in;
            end else begin : g_off
                always_ff @(posedge mclk) begin
                    gp2_in[i] <= 1'b0;
                end
            end
        end

        // third gp port, variant one only
        for (i = 0; i < `ULPC_V1_GP3_IN; i++) begin : g_gp3
            if (i < GP3_PIN) begin : g_on
                ulpc_pin_if pif ();
                assign pif.user_out = gp3_out[i];
                assign pif.user_dir = gp3_dir[i];
                assign pif.user_sel = (gp3_fn == `ULPC_FN_USER);
                ulpc_pin u_pin (
                    .mclk    (mclk),
                    .reset   (reset),
                    .pad_in  (gp3_pad_in[i]),
                    .user_in (gp3_in[i]),
                    .pin     (pif.ctrl)
                );
                assign gp3_pad_out[i] = pif.pad_out;
                assign gp3_pad_oe[i]  = pif.pad_oe;
            end else begin : g_off
                always_ff @(posedge mclk) begin
                    gp3_in[i]      <= 1'b0;
                    gp3_pad_out[i] <= 1'b0;
                    gp3_pad_oe[i]  <= 1'b0;
                end
            end
        end

        // backplane star lines, variant two only, always enabled
        if (V2) begin : g_star
            logic [2:0] star_sync;
            always_ff @(posedge mclk) begin
                if (reset) begin
                    star_sync <= 3'h0;
                end else begin
                    star_sync <= {star_sync[1:0], star_in_pad};
                end
            end
            always_ff @(posedge mclk) begin
                if (reset) begin
                    star_in      <= 1'b0;
                    star_out_pad <= 1'b0;
                end else begin
                    if (star_sync[1] == star_sync[2]) begin
                        star_in <= star_sync[2];
                    end
                    star_out_pad <= star_out;
                end
            end
        end else begin : g_nostar
            always_ff @(posedge mclk) begin
                star_in      <= 1'b0;
                star_out_pad <= 1'b0;
            end
        end
    endgenerate

    // user outputs are taken as already on mclk and are not resynchronised;
    // a user that holds directions at 0 leaves every pad undriven except the variant two gp2 fixed outputs and the star output
endmodule // ulpc_port_ctrl

// >>> dv/ulpc_pads.sv
// connector-side model: a pin reads back its own drive while enabled
`timescale 1ns/1ps
module ulpc_pads #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] ext_lvl,
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    output logic      [W-1:0] pad_in
);
    // far end yields while the device drives; contention is not modelled
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule // ulpc_pads

// >>> dv/ulpc_port_ctrl_chk.sv
// port-level assertions for the user logic port control block
`timescale 1ns/1ps
module ulpc_port_ctrl_chk #(
    parameter ulpc_pkg::ulpc_variant_t VARIANT = ulpc_pkg::ULPC_VARIANT_ONE
) (
    input wire logic               mclk,
    input wire logic               reset,
    input wire ulpc_pkg::ulpc_fn_t trig_fn,
    input wire ulpc_pkg::ulpc_fn_t gp2_fn,
    input wire logic               trig_out,
    input wire logic               trig_dir,
    input wire logic [7:0]         gp2_dir,
    input wire logic               trig_pad_in,
    input wire logic               trig_pad_out,
    input wire logic               trig_pad_oe,
    input wire logic               trig_term_low,
    input wire logic [7:0]         gp2_pad_oe,
    input wire logic [11:0]        gp1_pad_oe,
    input wire logic               trig_in
);
    import ulpc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // the first edge after reset still shows the reset value of the pads
    a_trig_oe_gate: assert property (!$past(reset) |->
        trig_pad_oe == ($past(trig_fn) == 2'h1 && $past(trig_dir)))
        else $error("trig enable wrong");
    a_trig_out_gate: assert property (!$past(reset) |->
        trig_pad_out == ($past(trig_fn) == 2'h1 && $past(trig_dir)
        && $past(trig_out))) else $error("trig drive wrong");
    a_trig_term_low: assert property (!$past(reset) |->
        trig_term_low == ($past(trig_fn) == 2'h1 && $past(trig_dir)
        && !$past(trig_out))) else $error("trig termination wrong");
    a_out_needs_oe: assert property (
        trig_pad_out |-> trig_pad_oe) else $error("drive without enable");
    a_term_needs_oe: assert property (
        trig_term_low |-> trig_pad_oe && !trig_pad_out)
        else $error("termination while driving high");
    a_gp2_oe_vec: assert property (!$past(reset) |->
        gp2_pad_oe == ($past(gp2_fn) != 2'h1 ? 8'h00 :
        VARIANT == ULPC_VARIANT_TWO ? 8'h70 : $past(gp2_dir)))
        else $error("gp2 enable wrong");
    a_gp1_upper_idle: assert property (
        VARIANT == ULPC_VARIANT_ONE |-> gp1_pad_oe[11:1] == 11'h000)
        else $error("gp1 absent pin driven");
    a_trig_in_sync: assert property (
        (!reset && $stable(trig_pad_in))[*5] |-> trig_in == trig_pad_in)
        else $error("trig input not followed");
endmodule // ulpc_port_ctrl_chk

bind ulpc_port_ctrl ulpc_port_ctrl_chk #(.VARIANT(VARIANT))
    u_ulpc_port_ctrl_chk (.*);

// >>> dv/ulpc_port_ctrl_tb.sv
// self-checking bench for the user logic port control block
`timescale 1ns/1ps
module ulpc_port_ctrl_tb;
    import ulpc_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    ulpc_fn_t    trig_fn, sync_fn, gp1_fn, gp2_fn, gp3_fn;
    logic        trig_ext, sync_pad_in, star_in_pad, star_out;
    logic        trig_out, trig_dir, sync_out, sync_dir;
    logic [11:0] gp1_pad_in, gp1_out, gp1_dir, gp1_pad_out, gp1_pad_oe;
    logic [7:0]  gp2_ext, gp2_out, gp2_dir, gp2_pad_out, gp2_pad_oe;
    logic [4:0]  gp3_pad_in, gp3_out, gp3_dir, gp3_pad_out, gp3_pad_oe;
    logic        trig_pad_in, trig_pad_out, trig_pad_oe, trig_term_low;
    logic        sync_pad_out, sync_pad_oe, sync_term_low, star_out_pad;
    logic        trig_in, sync_in, star_in;
    logic [11:0] gp1_in;
    logic [7:0]  gp2_pad_in, gp2_in;
    logic [4:0]  gp3_in;
    logic [11:0] v2_gp1_oe, v2_gp1_out, v2_gp1_in;
    logic [7:0]  v2_gp2_oe, v2_gp2_out, v2_gp2_in;
    logic        v2_star_pad, v2_star_in;
    int          mismatches = 0;
    int          n_tests = 0;
    int          exp_q[$];
    int          old_q[$];

    always #12.5 mclk = ~mclk;

    ulpc_port_ctrl u_ulpc_port_ctrl (.*);
    ulpc_pads u_ulpc_pads_trig (.ext_lvl(trig_ext), .pad_out(trig_pad_out),
        .pad_oe(trig_pad_oe), .pad_in(trig_pad_in));
    ulpc_pads #(.W(8)) u_ulpc_pads_gp2 (.ext_lvl(gp2_ext),
        .pad_out(gp2_pad_out), .pad_oe(gp2_pad_oe), .pad_in(gp2_pad_in));

    // second board variant on the same stimulus; its pads read no drive back
    ulpc_port_ctrl #(.VARIANT(ULPC_VARIANT_TWO)) u_ulpc_port_ctrl_v2 (
        .mclk(mclk), .reset(reset), .trig_fn(trig_fn), .sync_fn(sync_fn),
        .gp1_fn(gp1_fn), .gp2_fn(gp2_fn), .gp3_fn(gp3_fn),
        .trig_pad_in(trig_ext), .sync_pad_in(sync_pad_in),
        .gp1_pad_in(gp1_pad_in), .gp2_pad_in(gp2_ext),
        .gp3_pad_in(gp3_pad_in), .star_in_pad(star_in_pad),
        .trig_pad_out(), .trig_pad_oe(), .trig_term_low(),
        .sync_pad_out(), .sync_pad_oe(), .sync_term_low(),
        .gp1_pad_out(v2_gp1_out), .gp1_pad_oe(v2_gp1_oe),
        .gp2_pad_out(v2_gp2_out), .gp2_pad_oe(v2_gp2_oe),
        .gp3_pad_out(), .gp3_pad_oe(), .star_out_pad(v2_star_pad),
        .trig_in(), .trig_out(trig_out), .trig_dir(trig_dir),
        .sync_in(), .sync_out(sync_out), .sync_dir(sync_dir),
        .gp1_in(v2_gp1_in), .gp1_out(gp1_out), .gp1_dir(gp1_dir),
        .gp2_in(v2_gp2_in), .gp2_out(gp2_out), .gp2_dir(gp2_dir),
        .gp3_in(), .gp3_out(gp3_out), .gp3_dir(gp3_dir),
        .star_in(v2_star_in), .star_out(star_out));

    // variant two: direction bit n enables pins 2n and 2n+1
    function automatic int pair_dir(int d);
        int e = 0;
        for (int n = 0; n < 12; n++) begin
            e |= ((d >> (n / 2)) & 1) << n;
        end
        return e;
    endfunction

    function automatic ulpc_fn_t pick_fn();
        return ($urandom % 2) ? 2'h1 : 2'($urandom);
    endfunction

    function automatic int gate(ulpc_fn_t f, int d, int m);
        return (f === 2'h1 && reset === 1'b0) ? (d & m) : 0;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic drive_random();
        reset = ($urandom % 16) == 0;
        trig_fn = pick_fn();
        sync_fn = pick_fn();
        gp1_fn = pick_fn();
        gp2_fn = pick_fn();
        gp3_fn = pick_fn();
        {gp1_out, gp1_dir, gp2_out} = $urandom;
        {gp2_dir, gp3_out, gp3_dir, gp3_pad_in, gp2_ext} = 31'($urandom);
        {trig_out, trig_dir, sync_out, sync_dir} = 4'($urandom);
        {trig_ext, star_out, star_in_pad, sync_pad_in} = 4'($urandom);
        exp_q = {gate(trig_fn, trig_dir, 1),
            gate(trig_fn, trig_dir & trig_out, 1),
            gate(trig_fn, trig_dir & !trig_out, 1),
            gate(sync_fn, sync_dir, 1),
            gate(sync_fn, sync_dir & !sync_out, 1),
            gate(gp1_fn, gp1_dir, 1), gate(gp1_fn, gp1_dir & gp1_out, 1),
            gate(gp2_fn, gp2_dir & gp2_out, 255),
            gate(gp3_fn, gp3_dir, 31), gate(gp3_fn, gp3_dir & gp3_out, 31),
            gate(sync_fn, sync_dir & sync_out, 1), gate(gp2_fn, gp2_dir, 255),
            gate(gp1_fn, pair_dir(gp1_dir), 12'hFFF),
            gate(gp1_fn, pair_dir(gp1_dir) & gp1_out, 12'hFFF),
            gate(gp2_fn, 8'h70, 8'hFF), // direction ignored
            gate(gp2_fn, int'(gp2_out) << 4, 8'h70),
            gate(2'h1, star_out, 1)}; // star lines are never deselected
    endtask

    task automatic cmp_drive();
        check("trig_pad_oe", 32'(trig_pad_oe), exp_q.pop_front());
        check("trig_pad_out", 32'(trig_pad_out), exp_q.pop_front());
        check("trig_term", 32'(trig_term_low), exp_q.pop_front());
        check("sync_pad_oe", 32'(sync_pad_oe), exp_q.pop_front());
        check("sync_term", 32'(sync_term_low), exp_q.pop_front());
        check("gp1_pad_oe", 32'(gp1_pad_oe), exp_q.pop_front());
        check("gp1_pad_out", 32'(gp1_pad_out), exp_q.pop_front());
        check("gp2_pad_out", 32'(gp2_pad_out), exp_q.pop_front());
        check("gp3_pad_oe", 32'(gp3_pad_oe), exp_q.pop_front());
        check("gp3_pad_out", 32'(gp3_pad_out), exp_q.pop_front());
        check("star_out_pad", 32'(star_out_pad), 0);
        check("sync_pad_out", 32'(sync_pad_out), exp_q.pop_front());
        check("gp2_pad_oe", 32'(gp2_pad_oe), exp_q.pop_front());
        check("v2_gp1_oe", 32'(v2_gp1_oe), exp_q.pop_front());
        check("v2_gp1_out", 32'(v2_gp1_out), exp_q.pop_front());
        check("v2_gp2_oe", 32'(v2_gp2_oe), exp_q.pop_front());
        check("v2_gp2_out", 32'(v2_gp2_out), exp_q.pop_front());
        check("v2_star_pad", 32'(v2_star_pad), exp_q.pop_front());
    endtask

    task automatic cmp_in(input int q[$]);
        check("trig_in", 32'(trig_in), q.pop_front());
        check("sync_in", 32'(sync_in), q.pop_front());
        check("gp1_in", 32'(gp1_in), q.pop_front());
        check("gp2_in", 32'(gp2_in), q.pop_front());
        check("gp3_in", 32'(gp3_in), q.pop_front());
        check("star_in", 32'(star_in), q.pop_front());
        check("v2_gp1_in", 32'(v2_gp1_in), q.pop_front());
        check("v2_gp2_in", 32'(v2_gp2_in), q.pop_front());
        check("v2_star_in", 32'(v2_star_in), q.pop_front());
    endtask

    // pads change once, then the old level must last three edges
    task automatic input_round(input bit chk);
        {trig_dir, sync_dir, gp1_dir, gp2_dir, gp3_dir} = 27'h0;
        {trig_ext, sync_pad_in, star_in_pad, gp1_pad_in} = 15'($urandom);
        {gp2_ext, gp3_pad_in} = 13'($urandom);
        exp_q = {trig_ext, sync_pad_in, gp1_pad_in[0], gp2_ext, gp3_pad_in, 0,
            gp1_pad_in, gp2_ext[3:0], star_in_pad};
        repeat (chk ? 3 : 5) @(posedge mclk);
        #2;
        if (chk) cmp_in(old_q);
        @(posedge mclk);
        #2;
        cmp_in(exp_q);
        old_q = exp_q;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(88));
        {trig_fn, sync_fn, gp1_fn, gp2_fn, gp3_fn} = 10'h000;
        {trig_out, trig_dir, sync_out, sync_dir} = 4'h0;
        {trig_ext, star_out, star_in_pad, sync_pad_in} = 4'h0;
        {gp1_out, gp1_dir, gp1_pad_in, gp2_out, gp2_dir, gp2_ext} = 60'h0;
        {gp3_out, gp3_dir, gp3_pad_in} = 15'h0000;
        repeat (5) @(posedge mclk);
        #2;
        repeat (300) begin
            drive_random();
            @(posedge mclk);
            #2;
            cmp_drive();
        end
        reset = 1'b0;
        input_round(1'b0);
        repeat (30) input_round(1'b1);
        give_verdict();
    end

    // tests take about 430 cycles; allow several times that
    initial begin
        #75000;
        mismatches++;
        give_verdict();
    end
endmodule // ulpc_port_ctrl_tb
